// ==== logic/pmc_regs.sv ====
// Serial management slave with the MMD window, extended status, remote loopback and cable test control
// Assumes MDC and MDIO_IN come from pins, the test engine outside shares CLOCK, and MDC is below CLOCK/8
`timescale 1ns/1ps

// Operation
// - Function code 00: window access loads the MMD register address.
// - Data function codes: window reads and writes move data of the addressed MMD register.
// - Code 01 no increment, 10 increment on reads and writes, 11 on writes only.
// - Control register 13 holds function in 15:14 and device select in 4:0.
// - Window register is sixteen bits, read/write, resets to zero.
// - Extended status bit 13 always reads one, writes ignored.
// - Extended status bits 15, 14 and 12 read zero, read-only.
// - Loopback bit 8 enables remote loopback when one, resets to zero.
// - Writing one to bit 15 starts the test, zero aborts, completion clears it.
// - Bit 15 reads one while testing; zero means finished, results valid.
// - Bit 14 one disables transmitter and holds diagnosis; zero lets it run.
module pmc_regs #(
  parameter logic [4:0] PHY_ADDRESS = 5'h00
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic MDC,
  input wire logic MDIO_IN,
  input wire logic CABLE_TEST_DONE,
  output pmc_pkg::pmc_mdio_t MDIO,
  output pmc_pkg::pmc_cable_t CABLE,
  output logic REMOTE_LOOPBACK
);
  import pmc_pkg::*;

  pmc_state_t st;
  pmc_state_t next_st;
  logic mdc_rise;
  logic in_bit;
  logic wr_fire;
  logic rd_fire;
  logic [4:0] wr_reg;
  logic [15:0] wr_data;

  // Register read mux; unlisted indices and reserved bits read zero
  function automatic logic [15:0] rd_reg(input pmc_state_t s, input logic [4:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      REG_MMD_CTRL: begin
        v[CTL_FUNC_HI:CTL_FUNC_LO] = s.func;
        v[CTL_DEV_HI:0] = s.mmd_device_select;
      end
      REG_MMD_WINDOW: begin
        if (s.func == MMD_FUNC_ADDR) begin
          v = s.mmd_addr;
        end else begin
          v = s.mem[s.mmd_addr[MMD_IDX_W-1:0]];
        end
      end
      REG_EXT_STATUS: v = EXT_STATUS_VALUE;
      REG_REMOTE_LOOP: v[LOOP_BIT] = s.loop;
      REG_CABLE_TEST: begin
        v[CT_RUN_BIT] = s.run;
        v[CT_HOLD_BIT] = s.hold;
      end
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  assign mdc_rise = st.mdc_sync[1] & ~st.mdc_sync[2];
  assign in_bit = st.mdio_sync[1];
  assign wr_fire = mdc_rise && (st.frame == S_WDATA) && (st.cnt == 6'h0F);
  assign rd_fire = mdc_rise && (st.frame == S_TA) && (st.op == OP_READ);
  assign wr_reg = st.addr_sh[4:0];
  assign wr_data = {st.sh[14:0], in_bit};

  always_comb begin
    next_st = st;
    // MDC edges are read from its second and third stages; data is read from the second MDIO stage
    next_st.mdc_sync = {st.mdc_sync[1:0], MDC};
    next_st.mdio_sync = {st.mdio_sync[0], MDIO_IN};
    if (CABLE_TEST_DONE) begin
      next_st.run = 1'b0;
    end
    if (mdc_rise) begin
      case (st.frame)
        S_PRE: begin
          if (in_bit) begin
            if (st.cnt != PREAMBLE_LEN) begin
              next_st.cnt = st.cnt + 6'h01;
            end
          end else if (st.cnt == PREAMBLE_LEN) begin
            next_st.frame = S_START;
            next_st.cnt = 6'h00;
          end else begin
            next_st.cnt = 6'h00;
          end
        end
        S_START: begin
          next_st.frame = in_bit ? S_OP : S_PRE;
          next_st.cnt = 6'h00;
        end
        S_OP: begin
          next_st.op = {st.op[0], in_bit};
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == 6'h01) begin
            next_st.frame = S_ADDR;
            next_st.cnt = 6'h00;
          end
        end
        S_ADDR: begin
          next_st.addr_sh = {st.addr_sh[8:0], in_bit};
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == 6'h09) begin
            next_st.cnt = 6'h00;
            // Frames for other stations are dropped; a fresh preamble is needed after them
            if ((st.addr_sh[8:4] == PHY_ADDRESS) && ((st.op == OP_READ) || (st.op == OP_WRITE))) begin
              next_st.frame = S_TA;
            end else begin
              next_st.frame = S_PRE;
            end
          end
        end
        S_TA: begin
          next_st.cnt = st.cnt + 6'h01;
          if (st.op == OP_READ) begin
            // Fetch once so read side effects happen exactly once per frame
            next_st.sh = rd_reg(st, st.addr_sh[4:0]);
            next_st.mdio_out = 1'b0;
            next_st.mdio_oe_n = 1'b0;
            next_st.frame = S_RDATA;
            next_st.cnt = 6'h00;
            if ((st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func == MMD_FUNC_INC_RW)) begin
              next_st.mmd_addr = st.mmd_addr + MMD_ADDR_STEP;
            end
          end else if (st.cnt == 6'h01) begin
            next_st.frame = S_WDATA;
            next_st.cnt = 6'h00;
          end
        end
        S_RDATA: begin
          if (st.cnt == 6'h10) begin
            next_st.mdio_oe_n = 1'b1;
            next_st.mdio_out = 1'b0;
            next_st.frame = S_PRE;
            next_st.cnt = 6'h00;
          end else begin
            next_st.mdio_out = st.sh[15];
            next_st.sh = {st.sh[14:0], 1'b0};
            next_st.cnt = st.cnt + 6'h01;
          end
        end
        S_WDATA: begin
          next_st.sh = wr_data;
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == 6'h0F) begin
            next_st.frame = S_PRE;
            next_st.cnt = 6'h00;
          end
        end
        default: begin
          next_st.frame = S_PRE;
          next_st.cnt = 6'h00;
        end
      endcase
    end
    // Commit after the done clear, so a start written in the same cycle wins
    if (wr_fire) begin
      case (wr_reg)
        REG_MMD_CTRL: begin
          next_st.func = pmc_mmd_func_t'(wr_data[CTL_FUNC_HI:CTL_FUNC_LO]);
          next_st.mmd_device_select = wr_data[CTL_DEV_HI:0];
        end
        REG_MMD_WINDOW: begin
          if (st.func == MMD_FUNC_ADDR) begin
            next_st.mmd_addr = wr_data;
          end else begin
            next_st.mem[st.mmd_addr[MMD_IDX_W-1:0]] = wr_data;
            if (st.func != MMD_FUNC_DATA) begin
              next_st.mmd_addr = st.mmd_addr + MMD_ADDR_STEP;
            end
          end
        end
        REG_REMOTE_LOOP: next_st.loop = wr_data[LOOP_BIT];
        REG_CABLE_TEST: begin
          next_st.run = wr_data[CT_RUN_BIT];
          next_st.hold = wr_data[CT_HOLD_BIT];
        end
        // Capability word is fixed; writes to it change nothing
        REG_EXT_STATUS: next_st.run = next_st.run;
        default: next_st.run = next_st.run;
      endcase
    end
    next_st.diag_go = next_st.run & ~next_st.hold;
    next_st.tx_disable = next_st.run & next_st.hold;
    if (RST) begin
      next_st = '0;
      next_st.mmd_addr = WINDOW_RESET;
      next_st.mdio_oe_n = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    st <= next_st;
  end

  assign MDIO = '{out: st.mdio_out, oe_n: st.mdio_oe_n};
  assign CABLE = '{diag_go: st.diag_go, tx_disable: st.tx_disable};
  assign REMOTE_LOOPBACK = st.loop;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_addr_load: assert property (
    wr_fire && (wr_reg == REG_MMD_WINDOW) && (st.func == MMD_FUNC_ADDR) |=> st.mmd_addr == $past(wr_data)
  ) else $error("MMD address not loaded from window write");

  a_data_store: assert property (
    wr_fire && (wr_reg == REG_MMD_WINDOW) && (st.func == MMD_FUNC_DATA)
    |=> (st.mem[$past(st.mmd_addr[3:0])] == $past(wr_data)) && $stable(st.mmd_addr)
  ) else $error("MMD data write lost or address moved");

  a_incr_on_read: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func == MMD_FUNC_INC_RW)
    |=> st.mmd_addr == $past(st.mmd_addr) + 16'h0001
  ) else $error("MMD address did not advance after read");

  a_no_incr_wr_only: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func == MMD_FUNC_INC_WR) |=> $stable(st.mmd_addr)
  ) else $error("MMD address moved on read in write-increment mode");

  a_ctrl_reserved: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_CTRL) |=> (st.sh[13:5] == 9'h000) && (st.sh[15:14] == $past(st.func))
  ) else $error("Control register readback wrong");

  a_window_reset: assert property (
    $fell(RST) |-> (st.mmd_addr == 16'h0000) && (st.func == MMD_FUNC_ADDR)
  ) else $error("Window not zero after reset");

  a_ext_status: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_EXT_STATUS) |=> st.sh == 16'h2000
  ) else $error("Extended status read wrong");

  a_loop_follow: assert property (
    wr_fire && (wr_reg == REG_REMOTE_LOOP) |=> REMOTE_LOOPBACK == $past(wr_data[8])
  ) else $error("Remote loopback did not follow write");

  a_test_done_clear: assert property (
    CABLE_TEST_DONE && !(wr_fire && (wr_reg == REG_CABLE_TEST))
    |=> !st.run && !CABLE.diag_go && !CABLE.tx_disable
  ) else $error("Cable test not cleared at completion");

  a_test_status: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_CABLE_TEST) |=> st.sh[15] == $past(st.run)
  ) else $error("Cable test progress bit wrong");

  a_tx_hold: assert property (
    wr_fire && (wr_reg == REG_CABLE_TEST) && (wr_data[15:14] == 2'b11)
    |=> CABLE.tx_disable && !CABLE.diag_go
  ) else $error("Transmitter hold not applied");

  a_read_drive: assert property (
    rd_fire |=> !MDIO.oe_n && !MDIO.out ##1 !MDIO.oe_n
  ) else $error("Read turnaround not driven");

  a_ext_readonly: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_EXT_STATUS)
    |=> (st.sh[15:14] == 2'b00) && !st.sh[12]
  ) else $error("Extended status fixed-zero abilities read as set");

  a_addr_readback: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func == MMD_FUNC_ADDR)
    |=> st.sh == $past(st.mmd_addr)
  ) else $error("Window read in address mode wrong");

  a_data_read: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func != MMD_FUNC_ADDR)
    |=> st.sh == $past(st.mem[st.mmd_addr[3:0]])
  ) else $error("Window read in data mode wrong");

  a_incr_on_write: assert property (
    wr_fire && (wr_reg == REG_MMD_WINDOW) && ((st.func == MMD_FUNC_INC_RW) || (st.func == MMD_FUNC_INC_WR))
    |=> st.mmd_addr == $past(st.mmd_addr) + 16'h0001
  ) else $error("MMD address did not advance after write");

  a_no_incr_data: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func == MMD_FUNC_DATA) |=> $stable(st.mmd_addr)
  ) else $error("MMD address moved on read without increment");

  a_ctrl_write: assert property (
    wr_fire && (wr_reg == REG_MMD_CTRL)
    |=> (st.func == $past(wr_data[15:14])) && (st.mmd_device_select == $past(wr_data[4:0]))
  ) else $error("Control register write not stored");

  a_loop_reserved: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_REMOTE_LOOP) |=> (st.sh[15:9] == 7'h00) && (st.sh[7:0] == 8'h00)
  ) else $error("Loopback register reserved bits not zero");

  a_test_reserved: assert property (
    rd_fire && (st.addr_sh[4:0] == REG_CABLE_TEST) |=> st.sh[13:0] == 14'h0000
  ) else $error("Cable test register reserved bits not zero");

  a_test_abort: assert property (
    wr_fire && (wr_reg == REG_CABLE_TEST) && !wr_data[15]
    |=> !st.run && !CABLE.diag_go && !CABLE.tx_disable
  ) else $error("Cable test not stopped by abort write");

  a_test_go: assert property (
    wr_fire && (wr_reg == REG_CABLE_TEST) && (wr_data[15:14] == 2'b10)
    |=> CABLE.diag_go && !CABLE.tx_disable
  ) else $error("Diagnosis not released with transmitter running");

  c_window_read: cover property (rd_fire && (st.addr_sh[4:0] == REG_MMD_WINDOW) && (st.func != MMD_FUNC_ADDR));
  c_test_start: cover property (wr_fire && (wr_reg == REG_CABLE_TEST) && wr_data[15]);
  c_test_finish: cover property (st.run && CABLE_TEST_DONE);
  c_write_incr: cover property (wr_fire && (wr_reg == REG_MMD_WINDOW) && (st.func == MMD_FUNC_INC_WR));
  c_tx_hold: cover property (CABLE.tx_disable);
endmodule // pmc_regs

// ==== logic/pmc_pkg.sv ====
// Constants and types for the management register bank behind the serial management pins
// Assumes a single 25 MHz clock; the management clock pin is far slower than it and is sampled
package pmc_pkg;

  // Register indices on the serial management frame
  localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] REG_MMD_WINDOW = 5'h0E;
  localparam logic [4:0] REG_EXT_STATUS = 5'h0F;
  localparam logic [4:0] REG_REMOTE_LOOP = 5'h11;
  localparam logic [4:0] REG_CABLE_TEST = 5'h12;

  // Field positions
  localparam int CTL_FUNC_HI = 15;
  localparam int CTL_FUNC_LO = 14;
  localparam int CTL_DEV_HI = 4;
  localparam int LOOP_BIT = 8;
  localparam int CT_RUN_BIT = 15;
  localparam int CT_HOLD_BIT = 14;

  // Values
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h2000;
  localparam logic [15:0] WINDOW_RESET = 16'h0000;
  localparam logic [15:0] MMD_ADDR_STEP = 16'h0001;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam int MMD_IDX_W = 4;
  localparam int MMD_WORDS = 16;

  // Frame opcodes
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [1:0] {
    MMD_FUNC_ADDR = 2'h0,
    MMD_FUNC_DATA = 2'h1,
    MMD_FUNC_INC_RW = 2'h2,
    MMD_FUNC_INC_WR = 2'h3
  } pmc_mmd_func_t;

  typedef enum logic [2:0] {
    S_PRE = 3'h0,
    S_START = 3'h1,
    S_OP = 3'h2,
    S_ADDR = 3'h3,
    S_TA = 3'h4,
    S_RDATA = 3'h5,
    S_WDATA = 3'h6
  } pmc_frame_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pmc_mdio_t;

  typedef struct packed {
    logic diag_go;
    logic tx_disable;
  } pmc_cable_t;

  typedef struct packed {
    logic [2:0] mdc_sync;
    logic [1:0] mdio_sync;
    pmc_frame_t frame;
    logic [5:0] cnt;
    logic [1:0] op;
    logic [9:0] addr_sh;
    logic [15:0] sh;
    pmc_mmd_func_t func;
    logic [4:0] mmd_device_select;
    logic [15:0] mmd_addr;
    logic [MMD_WORDS-1:0][15:0] mem;
    logic loop;
    logic run;
    logic hold;
    logic mdio_out;
    logic mdio_oe_n;
    logic diag_go;
    logic tx_disable;
  } pmc_state_t;

endpackage

// ==== dv/pmc_host.sv ====
// Station management master model: clause-22 frames on MDC and its half of the data wire
// Assumes a pull-up on the wire, so a released driver reads as one
`timescale 1ns/1ps
module pmc_host (
  input wire logic clock,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv
);
  import pmc_pkg::*;
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end
  // Nine clock cycles per bit keeps MDC near 2.8 MHz
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'h1, op, phy, regad, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clock);
      mdc <= 1'b0;
      mdio_drv <= (op == OP_READ && i < 18) ? 1'b1 : bits[i];
      repeat (4) @(posedge clock);
      mdc <= 1'b1;
      if (i < 16) rd[i] = mdio_wire;
      repeat (4) @(posedge clock);
    end
    // Extra rise with the wire released adds one idle bit; the slave already let go of the wire on the last data rise
    @(posedge clock);
    mdc <= 1'b0;
    mdio_drv <= 1'b1;
    repeat (4) @(posedge clock);
    mdc <= 1'b1;
    repeat (4) @(posedge clock);
    mdc <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
endmodule // pmc_host

// ==== dv/pmc_regs_tb.sv ====
// Bench for the management register bank: a table of frames with expected reads and pins
// Assumes the host model owns MDC and the host half of the data wire
`timescale 1ns/1ps
module pmc_regs_tb;
  import pmc_pkg::*;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic CABLE_TEST_DONE = 1'b0;
  logic MDC;
  logic host_drv;
  logic [15:0] rdata;
  wire logic MDIO_IN;
  pmc_mdio_t MDIO;
  pmc_cable_t CABLE;
  logic REMOTE_LOOPBACK;
  int fail_count = 0;
  int cmp_count = 0;
  // Kind (0 write, 1 read, 2 done pulse, 3 foreign address), index, data, pins {loop, go, tx off}
  logic [25:0] seq [$] = '{
    {2'h1, 5'h0E, 16'h0000, 3'h0},
    {2'h1, 5'h11, 16'h0000, 3'h0},
    {2'h1, 5'h0F, 16'h2000, 3'h0},
    {2'h0, 5'h0F, 16'hFFFF, 3'h0},
    {2'h1, 5'h0F, 16'h2000, 3'h0},
    {2'h0, 5'h11, 16'hFFFF, 3'h4},
    {2'h1, 5'h11, 16'h0100, 3'h4},
    {2'h0, 5'h10, 16'hFFFF, 3'h4},
    {2'h1, 5'h10, 16'h0000, 3'h4},
    {2'h3, 5'h11, 16'h0000, 3'h4},
    {2'h0, 5'h11, 16'h0000, 3'h0},
    {2'h0, 5'h0D, 16'h0003, 3'h0},
    {2'h0, 5'h0E, 16'h0005, 3'h0},
    {2'h1, 5'h0E, 16'h0005, 3'h0},
    {2'h1, 5'h0D, 16'h0003, 3'h0},
    {2'h0, 5'h0D, 16'h4003, 3'h0},
    {2'h0, 5'h0E, 16'hA5A5, 3'h0},
    {2'h1, 5'h0E, 16'hA5A5, 3'h0},
    {2'h1, 5'h0E, 16'hA5A5, 3'h0},
    {2'h0, 5'h0D, 16'h8003, 3'h0},
    {2'h0, 5'h0E, 16'h1111, 3'h0},
    {2'h0, 5'h0E, 16'h2222, 3'h0},
    {2'h0, 5'h0D, 16'h0003, 3'h0},
    {2'h0, 5'h0E, 16'h0005, 3'h0},
    {2'h0, 5'h0D, 16'h8003, 3'h0},
    {2'h1, 5'h0E, 16'h1111, 3'h0},
    {2'h1, 5'h0E, 16'h2222, 3'h0},
    {2'h0, 5'h0D, 16'hC003, 3'h0},
    {2'h0, 5'h0E, 16'h3333, 3'h0},
    {2'h0, 5'h0E, 16'h4444, 3'h0},
    {2'h0, 5'h0D, 16'h0003, 3'h0},
    {2'h0, 5'h0E, 16'h0007, 3'h0},
    {2'h0, 5'h0D, 16'hC003, 3'h0},
    {2'h1, 5'h0E, 16'h3333, 3'h0},
    {2'h1, 5'h0E, 16'h3333, 3'h0},
    {2'h0, 5'h0E, 16'h5555, 3'h0},
    {2'h1, 5'h0E, 16'h4444, 3'h0},
    {2'h1, 5'h12, 16'h0000, 3'h0},
    {2'h0, 5'h12, 16'h8000, 3'h2},
    {2'h1, 5'h12, 16'h8000, 3'h2},
    {2'h2, 5'h12, 16'h0000, 3'h0},
    {2'h1, 5'h12, 16'h0000, 3'h0},
    {2'h0, 5'h12, 16'hC000, 3'h1},
    {2'h0, 5'h12, 16'h4000, 3'h0},
    {2'h1, 5'h12, 16'h4000, 3'h0},
    {2'h0, 5'h12, 16'hFFFF, 3'h1},
    {2'h1, 5'h12, 16'hC000, 3'h1}
  };
  // Wire level: slave drives when enabled, else the host or the pull-up
  assign MDIO_IN = MDIO.oe_n ? host_drv : MDIO.out;
  initial forever #20 CLOCK = ~CLOCK;
  pmc_regs #(.PHY_ADDRESS(5'h00)) u_pmc_regs (
    .CLOCK(CLOCK),
    .RST(RST),
    .MDC(MDC),
    .MDIO_IN(MDIO_IN),
    .CABLE_TEST_DONE(CABLE_TEST_DONE),
    .MDIO(MDIO),
    .CABLE(CABLE),
    .REMOTE_LOOPBACK(REMOTE_LOOPBACK)
  );
  pmc_host u_pmc_host (
    .clock(CLOCK),
    .mdio_wire(MDIO_IN),
    .mdc(MDC),
    .mdio_drv(host_drv)
  );
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    foreach (seq[i]) begin
      case (seq[i][25:24])
        2'h2: begin
          @(posedge CLOCK);
          CABLE_TEST_DONE <= 1'b1;
          @(posedge CLOCK);
          CABLE_TEST_DONE <= 1'b0;
          repeat (3) @(posedge CLOCK);
        end
        2'h3: u_pmc_host.frame(OP_WRITE, 5'h01, seq[i][23:19], seq[i][18:3], rdata);
        2'h1: u_pmc_host.frame(OP_READ, 5'h00, seq[i][23:19], 16'h0000, rdata);
        default: u_pmc_host.frame(OP_WRITE, 5'h00, seq[i][23:19], seq[i][18:3], rdata);
      endcase
      if (seq[i][25:24] == 2'h1) begin
        chk(seq[i][18:3], rdata);
      end
      chk({13'h0000, seq[i][2:0]}, {13'h0000, REMOTE_LOOPBACK, CABLE.diag_go, CABLE.tx_disable});
      $display("step %0d done", i);
    end
    test_done();
  end
  // About 590 cycles per frame; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge CLOCK);
    fail_count++;
    test_done();
  end
endmodule // pmc_regs_tb
